// [hdl/csiat_top.sv]
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "csiat_regs.svh"

module csiat_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Processor state
    input wire logic cpu_halt,
    // Serial pins
    output logic serial_clock_pin,
    output logic serial_data_out,
    input wire logic serial_data_in,
    output logic port_mode,
    // Interrupt
    output logic transfer_done_irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic aw_held_q, w_held_q, wr_fire, wr_lane0, rd_err, wr_err;
    logic [7:0] aw_addr_q, divisor_q;
    logic [31:0] w_data_q, rd_data;
    logic [3:0] w_strb_q;
    logic [5:0] mode_q, byte_interval_setting_q;
    logic [4:0] end_address_pointer_q, buffer_address_counter_q;
    logic [1:0] irq_stat_q, irq_stat_d, irq_mask_q;
    logic [7:0] buf_mem [0:31];
    csiat_pkg::csiat_state_t state_q;
    logic [2:0] bit_q;
    logic [7:0] serial_shift_register_q, div_q;
    logic [6:0] gap_q;
    logic phase_q, transfer_busy_flag_q, stop_q, done_ev_q, susp_ev_q, si_sync;
    logic tick, start_wr, stop_wr, start_ok, last_byte, lsb_first;
    // ----------------------------------------
    // Serial data input synchroniser
    // ----------------------------------------
    csiat_sync3 u_si_sync (.aclk(aclk), .aresetn(aresetn), .din(serial_data_in), .dout(si_sync));
    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lane0 = wr_fire && w_strb_q[0];
    // Every mapped control register is an aligned word at or below the last control offset
    assign wr_err = !aw_addr_q[`CSIAT_BUF_SEL_BIT] && (aw_addr_q > `CSIAT_OFF_IRQ_MASK || aw_addr_q[1:0] != 2'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held_q <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held_q <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSIAT_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `CSIAT_RESP_SLVERR : `CSIAT_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= `CSIAT_MODE_RST;
            end_address_pointer_q <= `CSIAT_ENDPTR_RST;
            byte_interval_setting_q <= `CSIAT_IVL_RST;
            divisor_q <= `CSIAT_DIV_RST;
            irq_mask_q <= `CSIAT_IRQ_RST;
        end else if (wr_lane0) begin
            case (aw_addr_q)
                `CSIAT_OFF_MODE: mode_q <= w_data_q[5:0];
                `CSIAT_OFF_ENDPTR: end_address_pointer_q <= w_data_q[4:0];
                `CSIAT_OFF_IVL: begin
                    // Interval is frozen while a run is busy, so a byte gap never changes length mid-run
                    if (!transfer_busy_flag_q) begin
                        byte_interval_setting_q <= w_data_q[5:0];
                    end
                end
                `CSIAT_OFF_DIV: divisor_q <= w_data_q[7:0];
                `CSIAT_OFF_IRQ_MASK: irq_mask_q <= w_data_q[1:0];
                default: ;
            endcase
        end
    end
    assign start_wr = wr_lane0 && (aw_addr_q == `CSIAT_OFF_TRIG) && w_data_q[`CSIAT_TRIG_START];
    assign stop_wr = wr_lane0 && (aw_addr_q == `CSIAT_OFF_TRIG) && w_data_q[`CSIAT_TRIG_STOP];
    // ----------------------------------------
    // Buffer memory
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (wr_lane0 && aw_addr_q[`CSIAT_BUF_SEL_BIT]) begin
            buf_mem[aw_addr_q[6:2]] <= w_data_q[7:0];
        end
        // Engine write comes last so it wins a same-cycle collision
        if (state_q == csiat_pkg::ST_NEXT && mode_q[`CSIAT_MODE_RXE]) begin
            buf_mem[buffer_address_counter_q] <= serial_shift_register_q;
        end
    end
    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_axi_araddr[`CSIAT_BUF_SEL_BIT]) begin
            rd_data[7:0] = buf_mem[s_axi_araddr[6:2]];
        end else begin
            case (s_axi_araddr)
                `CSIAT_OFF_MODE: rd_data[5:0] = mode_q;
                `CSIAT_OFF_TRIG: rd_data = 32'h0000_0000;
                `CSIAT_OFF_STAT: rd_data[1:0] = {stop_q, transfer_busy_flag_q};
                `CSIAT_OFF_ENDPTR: rd_data[4:0] = end_address_pointer_q;
                `CSIAT_OFF_ADDRCNT: rd_data[4:0] = buffer_address_counter_q;
                `CSIAT_OFF_IVL: rd_data[5:0] = byte_interval_setting_q;
                `CSIAT_OFF_DIV: rd_data[7:0] = divisor_q;
                `CSIAT_OFF_IRQ_STAT: rd_data[1:0] = irq_stat_q;
                `CSIAT_OFF_IRQ_MASK: rd_data[1:0] = irq_mask_q;
                default: rd_err = 1'b1;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CSIAT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `CSIAT_RESP_SLVERR : `CSIAT_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // ----------------------------------------
    // Transfer clock divider
    // ----------------------------------------
    assign tick = (div_q == 8'h00);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= `CSIAT_DIV_RST;
        end else if ((state_q == csiat_pkg::ST_SHIFT || state_q == csiat_pkg::ST_GAP) && !tick) begin
            div_q <= div_q - 8'h01;
        end else begin
            div_q <= divisor_q;
        end
    end
    // ----------------------------------------
    // Automatic transfer engine
    // ----------------------------------------
    assign start_ok = start_wr && mode_q[`CSIAT_MODE_UEN] && mode_q[`CSIAT_MODE_ATE]
                      && mode_q[`CSIAT_MODE_TXE];
    assign last_byte = (buffer_address_counter_q == end_address_pointer_q);
    assign lsb_first = mode_q[`CSIAT_MODE_DIR];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= csiat_pkg::ST_IDLE;
            buffer_address_counter_q <= 5'h00;
            bit_q <= 3'h0;
            phase_q <= 1'b0;
            serial_shift_register_q <= 8'h00;
            gap_q <= 7'h00;
            transfer_busy_flag_q <= 1'b0;
            serial_clock_pin <= 1'b1;
            serial_data_out <= 1'b1;
            port_mode <= 1'b1;
            done_ev_q <= 1'b0;
            susp_ev_q <= 1'b0;
        end else begin
            done_ev_q <= 1'b0;
            susp_ev_q <= 1'b0;
            if (!mode_q[`CSIAT_MODE_UEN]) begin
                // Unit disable is a hard stop: the byte is dropped and no event is raised
                state_q <= csiat_pkg::ST_IDLE;
                buffer_address_counter_q <= 5'h00;
                transfer_busy_flag_q <= 1'b0;
                serial_clock_pin <= 1'b1;
                port_mode <= 1'b1;
            end else begin
                case (state_q)
                    csiat_pkg::ST_IDLE: begin
                        if (start_ok) begin
                            state_q <= csiat_pkg::ST_LOAD;
                            transfer_busy_flag_q <= 1'b1;
                            port_mode <= 1'b0;
                        end
                    end
                    csiat_pkg::ST_LOAD: begin
                        serial_shift_register_q <= buf_mem[buffer_address_counter_q];
                        bit_q <= 3'h0;
                        phase_q <= 1'b0;
                        state_q <= csiat_pkg::ST_SHIFT;
                    end
                    csiat_pkg::ST_SHIFT: begin
                        if (tick) begin
                            if (!phase_q) begin
                                serial_clock_pin <= 1'b0;
                                // Data only moves on the falling clock edge
                                serial_data_out <= lsb_first ? serial_shift_register_q[0]
                                                             : serial_shift_register_q[7];
                                phase_q <= 1'b1;
                            end else begin
                                serial_clock_pin <= 1'b1;
                                phase_q <= 1'b0;
                                serial_shift_register_q <= lsb_first ? {si_sync, serial_shift_register_q[7:1]}
                                    : {serial_shift_register_q[6:0], si_sync};
                                if (bit_q == `CSIAT_BYTE_LAST_BIT) begin
                                    state_q <= csiat_pkg::ST_NEXT;
                                end else begin
                                    bit_q <= bit_q + 3'h1;
                                end
                            end
                        end
                    end
                    csiat_pkg::ST_NEXT: begin
                        if (last_byte && !mode_q[`CSIAT_MODE_RPT]) begin
                            done_ev_q <= 1'b1;
                            transfer_busy_flag_q <= 1'b0;
                            port_mode <= 1'b1;
                            buffer_address_counter_q <= 5'h00;
                            state_q <= csiat_pkg::ST_IDLE;
                        end else begin
                            // Repeat wraps silently to the first byte
                            buffer_address_counter_q <= last_byte ? 5'h00
                                                        : buffer_address_counter_q + 5'h01;
                            // A pending stop takes effect on the first gap cycle, so no byte is cut
                            gap_q <= {byte_interval_setting_q, 1'b0};
                            state_q <= csiat_pkg::ST_GAP;
                        end
                    end
                    csiat_pkg::ST_GAP: begin
                        if (stop_q) begin
                            susp_ev_q <= 1'b1;
                            transfer_busy_flag_q <= 1'b0;
                            port_mode <= 1'b1;
                            state_q <= csiat_pkg::ST_IDLE;
                        end else if (cpu_halt) begin
                            // Halt parks the engine between bytes; it resumes on release
                            state_q <= csiat_pkg::ST_GAP;
                        end else if (gap_q == 7'h00) begin
                            state_q <= csiat_pkg::ST_LOAD;
                        end else if (tick) begin
                            gap_q <= gap_q - 7'h01;
                        end
                    end
                    default: state_q <= csiat_pkg::ST_IDLE;
                endcase
            end
        end
    end
    // ----------------------------------------
    // Stop request
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_q <= 1'b0;
        end else if (stop_wr && transfer_busy_flag_q) begin
            stop_q <= 1'b1;
        end else if (!transfer_busy_flag_q) begin
            stop_q <= 1'b0;
        end
    end
    // ----------------------------------------
    // Interrupt status and output
    // ----------------------------------------
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_lane0 && aw_addr_q == `CSIAT_OFF_IRQ_STAT) begin
            irq_stat_d = irq_stat_d & ~w_data_q[1:0];
        end
        // A new event wins over a same-cycle clear
        irq_stat_d[`CSIAT_IRQ_DONE] = irq_stat_d[`CSIAT_IRQ_DONE] | done_ev_q;
        irq_stat_d[`CSIAT_IRQ_SUSP] = irq_stat_d[`CSIAT_IRQ_SUSP] | susp_ev_q;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= `CSIAT_IRQ_RST;
            transfer_done_irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            transfer_done_irq <= |(irq_stat_d & irq_mask_q);
        end
    end

endmodule

`default_nettype wire

// [hdl/csiat_regs.svh]
`ifndef CSIAT_REGS_SVH
`define CSIAT_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSIAT_OFF_MODE 8'h00
`define CSIAT_OFF_TRIG 8'h04
`define CSIAT_OFF_STAT 8'h08
`define CSIAT_OFF_ENDPTR 8'h0C
`define CSIAT_OFF_ADDRCNT 8'h10
`define CSIAT_OFF_IVL 8'h14
`define CSIAT_OFF_DIV 8'h18
`define CSIAT_OFF_IRQ_STAT 8'h1C
`define CSIAT_OFF_IRQ_MASK 8'h20
// Buffer words live where address bit 7 is set
`define CSIAT_BUF_SEL_BIT 7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSIAT_MODE_UEN 0
`define CSIAT_MODE_ATE 1
`define CSIAT_MODE_RPT 2
`define CSIAT_MODE_TXE 3
`define CSIAT_MODE_RXE 4
`define CSIAT_MODE_DIR 5
`define CSIAT_TRIG_START 0
`define CSIAT_TRIG_STOP 1
`define CSIAT_IRQ_DONE 0
`define CSIAT_IRQ_SUSP 1

// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define CSIAT_MODE_RST 6'h00
`define CSIAT_ENDPTR_RST 5'h00
`define CSIAT_IVL_RST 6'h00
`define CSIAT_DIV_RST 8'h04
`define CSIAT_IRQ_RST 2'h0
`define CSIAT_RESP_OKAY 2'h0
`define CSIAT_RESP_SLVERR 2'h2
`define CSIAT_BYTE_LAST_BIT 3'h7

`endif

// [hdl/csiat_pkg.sv]
package csiat_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_NEXT  = 3'b011,
        ST_GAP   = 3'b100
    } csiat_state_t;

endpackage

// [hdl/csiat_sync3.sv]
`timescale 1ns/10ps
`default_nettype none

module csiat_sync3 (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous level in, filtered level out
    input wire logic din,
    output logic dout
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout <= 1'b0;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end

endmodule

`default_nettype wire

// [tb/csiat_top_monitor.sv]
`timescale 1ns/10ps
`default_nettype none

module csiat_top_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial side and interrupt
    input wire logic serial_clock_pin,
    input wire logic serial_data_out,
    input wire logic port_mode,
    input wire logic transfer_done_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Falls per run wrap at eight, so a clean stop leaves zero behind
    logic [2:0] falls_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || port_mode) begin
            falls_q <= 3'h0;
        end else if ($fell(serial_clock_pin)) begin
            falls_q <= falls_q + 3'h1;
        end
    end

    AST_RST_IDLE: assert property ($past(!aresetn) |-> port_mode && serial_clock_pin && !transfer_done_irq)
        else $error("pins not idle after reset");
    AST_SDO_ON_FALL: assert property (!port_mode && $changed(serial_data_out) |-> $fell(serial_clock_pin))
        else $error("data moved off the clock fall");
    AST_BYTE_WHOLE: assert property ($rose(port_mode) |-> falls_q == 3'h0)
        else $error("run ended inside a byte");
    AST_SCK_IDLE: assert property (port_mode |-> serial_clock_pin)
        else $error("clock not parked in port mode");
    AST_IRQ_AT_IDLE: assert property ($rose(transfer_done_irq) |-> port_mode)
        else $error("interrupt while still busy");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not retired");
    AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not retired");

    COV_RUN_END: cover property ($rose(port_mode));
    COV_IRQ: cover property ($rose(transfer_done_irq));
    COV_BIT: cover property ($fell(serial_clock_pin));
endmodule

bind csiat_top csiat_top_monitor csiat_top_monitor_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .serial_clock_pin, .serial_data_out, .port_mode, .transfer_done_irq);

`default_nettype wire

// [tb/csiat_serial_peer.sv]
`timescale 1ns/10ps
`default_nettype none

module csiat_serial_peer (
    // Clock and pins
    input wire logic aclk,
    input wire logic serial_clock_pin,
    input wire logic serial_data_out,
    input wire logic port_mode,
    output logic serial_data_in
);
    logic [7:0] rx_q[$];
    logic [7:0] sh_q = 8'h00;
    logic [2:0] nb_q = 3'h0;
    logic [15:0] run_q = 16'h0000;
    logic [15:0] hi_max = 16'h0000;
    logic pm_q = 1'b1;

    // Receive is off in every run, so a toggling line exposes any write-back
    initial serial_data_in = 1'b0;
    always @(posedge aclk) serial_data_in <= ~serial_data_in;

    always @(posedge serial_clock_pin) begin
        if (!port_mode) begin
            sh_q = {sh_q[6:0], serial_data_out};
            if (nb_q == 3'h7) rx_q.push_back(sh_q);
            nb_q = nb_q + 3'h1;
        end
    end

    // Longest high stretch in a run; the gaps between bytes set it
    always @(posedge aclk) begin
        pm_q <= port_mode;
        run_q <= (serial_clock_pin && !port_mode) ? run_q + 16'h0001 : 16'h0000;
        if (pm_q && !port_mode) hi_max <= 16'h0000;
        else if (run_q > hi_max) hi_max <= run_q;
    end
endmodule

`default_nettype wire

// [tb/tb_csiat_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csiat_regs.svh"

module tb_csiat_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, cpu_halt = 1'b0, serial_data_in;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic serial_clock_pin, serial_data_out, port_mode, transfer_done_irq;
    logic [7:0] pat [4] = '{8'h83, 8'h3C, 8'h5A, 8'hF0};
    int err_total = 0, compares = 0, base, g0;

    always #12.5 aclk = ~aclk;

    csiat_top csiat_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_halt,
        .serial_clock_pin, .serial_data_out, .serial_data_in, .port_mode, .transfer_done_irq);
    csiat_serial_peer csiat_serial_peer_inst (.aclk, .serial_clock_pin, .serial_data_out, .port_mode,
        .serial_data_in);

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa = 1'b1, pw = 1'b1;
        int n = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            n++;
            if (pa && s_axi_awready === 1'b1) begin pa = 1'b0; s_axi_awvalid <= 1'b0; end
            if (pw && s_axi_wready === 1'b1) begin pw = 1'b0; s_axi_wvalid <= 1'b0; end
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        chk(32'(s_axi_bresp), 32'h0000_0000);
        s_axi_bready <= 1'b0;
        if (n >= 200) err_total++;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa = 1'b1;
        int n = 0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            n++;
            if (pa && s_axi_arready === 1'b1) begin pa = 1'b0; s_axi_arvalid <= 1'b0; end
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 200) err_total++;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
    endtask

    // Completion is judged from the busy flag, never from the interrupt
    task automatic idle();
        logic [31:0] d;
        logic [1:0] r;
        int n = 0;
        do begin rd(`CSIAT_OFF_STAT, d, r); n++; end while (d[0] !== 1'b0 && n < 500);
        if (n >= 500) err_total++;
    endtask

    task automatic wait_bytes(input int k);
        int n = 0;
        while (csiat_serial_peer_inst.rx_q.size() < k && n < 5000) begin @(posedge aclk); n++; end
        if (n >= 5000) err_total++;
    endtask

    // End pointer is the byte count minus one
    task automatic go(input logic [5:0] m, input logic [4:0] ep, input logic [5:0] iv);
        base = csiat_serial_peer_inst.rx_q.size();
        wr(`CSIAT_OFF_ENDPTR, {27'h000_0000, ep});
        wr(`CSIAT_OFF_IVL, {26'h000_0000, iv});
        wr(`CSIAT_OFF_MODE, {26'h000_0000, m});
        wr(`CSIAT_OFF_TRIG, 32'h0000_0001);
    endtask

    task automatic chk_run(input int k);
        chk(csiat_serial_peer_inst.rx_q.size() - base, k);
        for (int i = 0; i < k; i++) chk(csiat_serial_peer_inst.rx_q[base + i], pat[i]);
    endtask

    task automatic summarize();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rchk(`CSIAT_OFF_MODE, 32'h0000_0000);
        rchk(`CSIAT_OFF_DIV, 32'h0000_0004);
        rd(8'h40, d, r);
        chk(32'(r), 32'h0000_0002);
        for (int i = 0; i < 4; i++) wr(8'h80 + 8'(4 * i), {24'h00_0000, pat[i]});
        wr(`CSIAT_OFF_DIV, 32'h0000_0003);
        wr(`CSIAT_OFF_IRQ_MASK, 32'h0000_0001);
        $display("test reset done");
    endtask

    task automatic t_auto();
        go(6'h0B, 5'h03, 6'h00);
        rchk(`CSIAT_OFF_STAT, 32'h0000_0001);
        idle();
        chk_run(4);
        g0 = csiat_serial_peer_inst.hi_max;
        chk(transfer_done_irq, 1'b1);
        rchk(`CSIAT_OFF_IRQ_STAT, 32'h0000_0001);
        rchk(8'h80, {24'h00_0000, pat[0]});
        wr(`CSIAT_OFF_IRQ_STAT, 32'h0000_0003);
        repeat (2) @(posedge aclk);
        chk(transfer_done_irq, 1'b0);
        go(6'h2B, 5'h00, 6'h00);
        idle();
        chk(csiat_serial_peer_inst.rx_q[base], {<<{pat[0]}});
        wr(`CSIAT_OFF_IRQ_STAT, 32'h0000_0003);
        go(6'h03, 5'h00, 6'h00);
        repeat (50) @(posedge aclk);
        chk(csiat_serial_peer_inst.rx_q.size(), base);
        $display("test auto done");
    endtask

    task automatic t_repeat();
        logic [31:0] d;
        logic [1:0] r;
        go(6'h0F, 5'h01, 6'h00);
        wait_bytes(base + 5);
        wr(`CSIAT_OFF_TRIG, 32'h0000_0002);
        idle();
        for (int i = 0; i < 5; i++) chk(csiat_serial_peer_inst.rx_q[base + i], pat[i % 2]);
        chk(transfer_done_irq, 1'b0);
        rd(`CSIAT_OFF_IRQ_STAT, d, r);
        chk(d[0], 1'b0);
        wr(`CSIAT_OFF_IRQ_STAT, 32'h0000_0003);
        $display("test repeat done");
    endtask

    task automatic t_suspend();
        go(6'h0B, 5'h03, 6'h03);
        wr(`CSIAT_OFF_TRIG, 32'h0000_0002);
        idle();
        chk(csiat_serial_peer_inst.rx_q.size() - base, 1);
        chk(port_mode, 1'b1);
        rchk(`CSIAT_OFF_ADDRCNT, 32'h0000_0001);
        wr(`CSIAT_OFF_TRIG, 32'h0000_0001);
        idle();
        chk_run(4);
        chk(csiat_serial_peer_inst.hi_max - g0, 24);
        wr(`CSIAT_OFF_IRQ_STAT, 32'h0000_0003);
        $display("test suspend done");
    endtask

    task automatic t_halt();
        logic [31:0] d;
        logic [1:0] r;
        int k;
        go(6'h0B, 5'h03, 6'h03);
        wait_bytes(base + 1);
        @(posedge aclk);
        cpu_halt <= 1'b1;
        repeat (300) @(posedge aclk);
        k = csiat_serial_peer_inst.rx_q.size();
        repeat (100) @(posedge aclk);
        chk(csiat_serial_peer_inst.rx_q.size(), k);
        rd(`CSIAT_OFF_STAT, d, r);
        chk(d[0], 1'b1);
        cpu_halt <= 1'b0;
        idle();
        chk_run(4);
        $display("test halt done");
    endtask

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_auto();
        t_repeat();
        t_suspend();
        t_halt();
        summarize();
    end

    // Whole run needs well under 20000 cycles
    initial begin
        #1000000;
        err_total++;
        summarize();
    end
endmodule

`default_nettype wire
